// File: rtl/sfs_pkg.sv
// Purpose: shared constants for the serial flash front end and its host
// Assumes: 200 MHz system clock on both ends
// Notes:   opcodes and host register offsets are local choices
`default_nettype none
package sfs_pkg;
  // ****************************************
  // clock and link timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int SCK_HALF_NS   = 80;
  localparam int SCK_HALF_CYC  = (SCK_HALF_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int BYTE_BITS     = 8;

  // ****************************************
  // status register layout and reset values
  // ****************************************
  localparam int ST_BUSY = 0;
  localparam int ST_WEL  = 1;
  localparam int ST_BP0  = 2;
  localparam int ST_BP1  = 3;
  localparam int ST_AAI  = 6;
  localparam int ST_LOCK = 7;
  localparam logic [1:0] RESERVED_VAL   = 2'h0;
  localparam logic       BP_RESET       = 1'b1;
  localparam logic       LOCK_RESET     = 1'b0;
  localparam logic       WEL_RESET      = 1'b0;

  // ****************************************
  // command opcodes
  // ****************************************
  localparam logic [7:0] OP_STATUS_READ   = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE  = 8'h01;
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;

  // ****************************************
  // host register map (wishbone, byte addresses)
  // ****************************************
  localparam int         ADR_W      = 4;
  localparam logic [3:0] REG_DATA   = 4'h0;
  localparam logic [3:0] REG_CTRL   = 4'h4;
  localparam logic [3:0] REG_STAT   = 4'h8;
  localparam int CTRL_SELECT = 0;
  localparam int CTRL_HOLD   = 1;
  localparam int CTRL_WP_HI  = 2;
  localparam int CTRL_MODE3  = 3;
  localparam int CTRL_W      = 4;
  localparam int STAT_XFER   = 0;

  typedef enum logic [1:0] {
    SFS_IDLE  = 2'b01,
    SFS_SHIFT = 2'b10
  } sfs_state_t;
endpackage
`default_nettype wire

// File: rtl/sfs_link_if.sv
// Purpose: four-wire serial link plus hold and write protect
// Assumes: one device, one host
// Notes:   released data out reads high, as through a pull-up
`timescale 1ns/1ps
`default_nettype none
interface sfs_link_if;
  logic sck;
  logic cs_n;
  logic si;
  logic so;
  logic so_oe_n;
  logic hold_n;
  logic wp_n;
  logic so_line;

  // ****************************************
  // wire resolution
  // ****************************************
  // pull-up stands in for the released line
  assign so_line = so_oe_n ? 1'b1 : so;

  modport device (input sck, cs_n, si, hold_n, wp_n, output so, so_oe_n);
  modport host   (output sck, cs_n, si, hold_n, wp_n, input so_line);
endinterface
`default_nettype wire

// File: rtl/sfs_device.sv
// Purpose: serial flash front end, device end: framing, hold, status reg
// Assumes: link pins are asynchronous; sck at most 1/16 of clk_i
// Notes:   erase/program engines live outside; busy/aai/wel events come in
//
// Contract
// - capture input bits on sck rising edges
// - change serial output on sck falling edges
// - chip select falling starts a transaction
// - work with sck idling low or high
// - hold entry only while chip selected
// - enter hold at first sck low
// - leave hold at first sck low
// - hold releases output, freezes transfer progress
// - deselect during hold resets interface, stays held
// - write protect low plus lock rejects writes
// - status bit 0 shows busy
// - status bit 1 shows write enable latch
// - bits 2,3 protection level, reset ones
// - bits 4,5 reserved, read zero
// - bit 6 shows auto-increment programming mode
// - lock bit makes protection bits read-only (here only while write protect is low; with it high they stay writable)
// - while busy only status reads served
// - write enable latch auto-clears on completions
// - bytes shifted msb first, eight bits
// - early deselect aborts current instruction
//
// The placing of the registers and the Wishbone register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module sfs_device
  import sfs_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  sfs_link_if.device      link,
  input  wire logic       busy_i,
  input  wire logic       aai_mode_i,
  input  wire logic       wel_clear_i,
  output logic            cmd_valid_o,
  output logic [7:0]      cmd_code_o,
  output logic [7:0]      status_o,
  output logic            held_o
);
  import sfs_pkg::*;

  // ****************************************
  // pin synchronisers
  // ****************************************
  // order: sck, cs_n, si, hold_n, wp_n
  logic [4:0] pin_meta_q;
  logic [4:0] pin_sync_q;
  logic       sck_prev_q;
  logic       cs_prev_q;

  // two stages before any logic looks at a pin
  // reset to idle levels: sck low, deselected, hold and protect released
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta_q <= 5'h0b;
      pin_sync_q <= 5'h0b;
    end else begin
      pin_meta_q <= {link.sck, link.cs_n, link.si, link.hold_n, link.wp_n};
      pin_sync_q <= pin_meta_q;
    end
  end

  logic sck_s;
  logic cs_n_s;
  logic si_s;
  logic hold_n_s;
  logic wp_n_s;
  assign {sck_s, cs_n_s, si_s, hold_n_s, wp_n_s} = pin_sync_q;

  // edge history sits after the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_prev_q <= 1'b0;
      cs_prev_q  <= 1'b1;
    end else begin
      sck_prev_q <= sck_s;
      cs_prev_q  <= cs_n_s;
    end
  end

  // ****************************************
  // hold tracking
  // ****************************************
  logic held_q;
  logic active;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;

  // held state set only while sck is low; cleared while sck is low or while deselected
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      held_q <= 1'b0;
    end else if (!hold_n_s && !sck_s && (!cs_n_s || held_q)) begin
      held_q <= 1'b1;
    end else if (hold_n_s && (!sck_s || cs_n_s)) begin
      held_q <= 1'b0;
    end
  end

  // edges in hold are ignored, so progress is kept
  assign active   = !cs_n_s && !held_q;
  assign sck_rise = active && sck_s && !sck_prev_q;
  assign sck_fall = active && !sck_s && sck_prev_q;
  assign cs_fall  = !cs_n_s && cs_prev_q;

  // ****************************************
  // byte assembly
  // ****************************************
  logic [2:0] bit_cnt_q;
  logic [7:0] in_sr_q;
  logic       first_done_q;
  logic [7:0] opcode_q;
  logic [7:0] rx_byte;
  logic       byte_done;

  assign rx_byte   = {in_sr_q[6:0], si_s};
  assign byte_done = sck_rise && (bit_cnt_q == 3'(BYTE_BITS - 1));

  // deselect clears the count, so a cut byte never completes
  always_ff @(posedge clk_i) begin
    if (rst_i || cs_n_s || cs_fall) begin
      bit_cnt_q    <= 3'h0;
      first_done_q <= 1'b0;
      in_sr_q      <= 8'h00;
      opcode_q     <= 8'h00;
    end else if (sck_rise) begin
      in_sr_q   <= rx_byte;
      bit_cnt_q <= bit_cnt_q + 3'h1;
      if (byte_done && !first_done_q) begin
        first_done_q <= 1'b1;
        opcode_q     <= rx_byte;
      end
    end
  end

  logic op_done;
  logic data_done;
  assign op_done   = byte_done && !first_done_q;
  assign data_done = byte_done && first_done_q;

  // ****************************************
  // status register
  // ****************************************
  logic       bp_lo_q;
  logic       bp_hi_q;
  logic       lock_q;
  logic       wel_q;
  logic       status_wr;
  logic [7:0] status_now;

  // lock only bites while write protect is low
  assign status_wr = data_done && opcode_q == OP_STATUS_WRITE && !busy_i
                     && !(lock_q && !wp_n_s);

  always_comb begin
    status_now          = 8'h00;
    status_now[ST_BUSY] = busy_i;
    status_now[ST_WEL]  = wel_q;
    status_now[ST_BP0]  = bp_lo_q;
    status_now[ST_BP1]  = bp_hi_q;
    status_now[ST_BP1+2:ST_BP1+1] = RESERVED_VAL;
    status_now[ST_AAI]  = aai_mode_i;
    status_now[ST_LOCK] = lock_q;
  end

  // writable bits only; reserved and read-only bits never stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bp_lo_q <= BP_RESET;
      bp_hi_q <= BP_RESET;
      lock_q  <= LOCK_RESET;
    end else if (status_wr) begin
      bp_lo_q <= rx_byte[ST_BP0];
      bp_hi_q <= rx_byte[ST_BP1];
      lock_q  <= rx_byte[ST_LOCK];
    end
  end

  // enable command wins over a same-cycle completion clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wel_q <= WEL_RESET;
    end else if (op_done && rx_byte == OP_WRITE_ENABLE && !busy_i) begin
      wel_q <= 1'b1;
    end else if (wel_clear_i
                 || (op_done && rx_byte == OP_WRITE_DISABLE && !busy_i)) begin
      wel_q <= 1'b0;
    end
  end

  // ****************************************
  // command hand-off to the memory engines
  // ****************************************
  // busy device drops every opcode except the status read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_valid_o <= 1'b0;
      cmd_code_o  <= 8'h00;
    end else begin
      cmd_valid_o <= op_done && !busy_i
                     && rx_byte != OP_STATUS_READ
                     && rx_byte != OP_STATUS_WRITE
                     && rx_byte != OP_WRITE_ENABLE
                     && rx_byte != OP_WRITE_DISABLE;
      if (op_done) begin
        cmd_code_o <= rx_byte;
      end
    end
  end

  // ****************************************
  // serial output
  // ****************************************
  logic       reading_q;
  logic [7:0] out_sr_q;
  logic [2:0] out_cnt_q;
  logic       drive_q;
  logic       so_q;
  logic       oe_n_q;

  // status read repeats, fresh snapshot every byte so busy can be polled
  always_ff @(posedge clk_i) begin
    if (rst_i || cs_n_s) begin
      reading_q <= 1'b0;
      drive_q   <= 1'b0;
      out_cnt_q <= 3'h0;
      out_sr_q  <= 8'h00;
      so_q      <= 1'b0;
    end else if (op_done && rx_byte == OP_STATUS_READ) begin
      reading_q <= 1'b1;
      out_sr_q  <= status_now;
    end else if (sck_fall && reading_q) begin
      drive_q   <= 1'b1;
      so_q      <= out_sr_q[7];
      out_cnt_q <= out_cnt_q + 3'h1;
      if (out_cnt_q == 3'(BYTE_BITS - 1)) begin
        out_sr_q <= status_now;
      end else begin
        out_sr_q <= {out_sr_q[6:0], 1'b0};
      end
    end
  end

  // released in hold and while deselected
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oe_n_q <= 1'b1;
    end else begin
      oe_n_q <= !(drive_q && active);
    end
  end

  assign link.so      = so_q;
  assign link.so_oe_n = oe_n_q;
  assign status_o     = status_now;
  assign held_o       = held_q;
endmodule
`default_nettype wire

// File: rtl/sfs_host.sv
// Purpose: host end: wishbone-driven byte shifter for the flash link
// Assumes: software sequences select, hold and write protect itself
// Notes:   sck is made here by a divider; one byte per data write
`timescale 1ns/1ps
`default_nettype none
module sfs_host
  import sfs_pkg::*;
#(
  parameter int HALF_DIV = sfs_pkg::SCK_HALF_CYC
)(
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [sfs_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  sfs_link_if.host                       link
);
  import sfs_pkg::*;

  // ****************************************
  // wishbone slave
  // ****************************************
  logic                ack_q;
  logic                acc;
  logic                wr;
  logic [CTRL_W-1:0]   ctrl_q;
  logic [7:0]          rx_data_q;
  sfs_state_t          state_q;
  logic                start;

  assign acc   = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr    = acc && wb_we_i && wb_sel_i[0];
  // data write during a transfer is dropped
  assign start = wr && wb_adr_i == REG_DATA && state_q == SFS_IDLE;

  // one wait state, ack drops after one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q    <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack_q    <= acc;
      wb_dat_o <= 32'h0000_0000;
      if (acc && !wb_we_i) begin
        case (wb_adr_i)
          REG_DATA: wb_dat_o[7:0] <= rx_data_q;
          REG_CTRL: wb_dat_o[CTRL_W-1:0] <= ctrl_q;
          REG_STAT: wb_dat_o[STAT_XFER] <= state_q != SFS_IDLE;
          default:  wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign wb_ack_o = ack_q;

  // pin levels under software control
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= 4'h4;
    end else if (wr && wb_adr_i == REG_CTRL) begin
      ctrl_q <= wb_dat_i[CTRL_W-1:0];
    end
  end

  // ****************************************
  // data-out synchroniser
  // ****************************************
  logic so_meta_q;
  logic so_s_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      so_meta_q <= 1'b1;
      so_s_q    <= 1'b1;
    end else begin
      so_meta_q <= link.so_line;
      so_s_q    <= so_meta_q;
    end
  end

  // ****************************************
  // byte shifter
  // ****************************************
  logic [15:0] div_q;
  logic        tick;
  logic [3:0]  tog_q;
  logic        sck_q;
  logic        si_q;
  logic        rose_q;
  logic [7:0]  tx_sr_q;
  logic [7:0]  rx_sr_q;

  // half-period enable; frozen in hold so the clock pauses low or high
  assign tick = state_q == SFS_SHIFT && !ctrl_q[CTRL_HOLD]
                && div_q == 16'(HALF_DIV - 1);

  // hold restarts the divider: after a hold the device needs a full half
  // period to leave hold and drive data out again before the next rise
  always_ff @(posedge clk_i) begin
    if (rst_i || state_q == SFS_IDLE || tick || ctrl_q[CTRL_HOLD]) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  // mode 3 starts with a fall, mode 0 with a rise; 16 toggles either way
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q   <= SFS_IDLE;
      sck_q     <= 1'b0;
      si_q      <= 1'b0;
      rose_q    <= 1'b0;
      tog_q     <= 4'h0;
      tx_sr_q   <= 8'h00;
      rx_sr_q   <= 8'h00;
      rx_data_q <= 8'h00;
    end else begin
      case (state_q)
        SFS_IDLE: begin
          sck_q <= ctrl_q[CTRL_MODE3];
          if (start) begin
            state_q <= SFS_SHIFT;
            tx_sr_q <= wb_dat_i[7:0];
            si_q    <= wb_dat_i[7];
            rose_q  <= 1'b0;
            tog_q   <= 4'h0;
          end
        end
        SFS_SHIFT: begin
          if (tick) begin
            sck_q <= !sck_q;
            tog_q <= tog_q + 4'h1;
            if (!sck_q) begin
              rx_sr_q <= {rx_sr_q[6:0], so_s_q};
              rose_q  <= 1'b1;
            end else if (rose_q) begin
              si_q    <= tx_sr_q[6];
              tx_sr_q <= {tx_sr_q[6:0], 1'b0};
            end
            if (tog_q == 4'hF) begin
              state_q   <= SFS_IDLE;
              rx_data_q <= !sck_q ? {rx_sr_q[6:0], so_s_q} : rx_sr_q;
            end
          end
        end
        default: state_q <= SFS_IDLE;
      endcase
    end
  end

  assign link.sck    = sck_q;
  assign link.si     = si_q;
  assign link.cs_n   = !ctrl_q[CTRL_SELECT];
  assign link.hold_n = !ctrl_q[CTRL_HOLD];
  assign link.wp_n   = ctrl_q[CTRL_WP_HI];
endmodule
`default_nettype wire

// File: test/sfs_link_properties.sv
// Purpose: link properties for the flash front end pair
// Assumes: link pins sampled on the 200 MHz clock, HALF_DIV of 8
// Notes:   plain inputs, placed beside the link interface
`timescale 1ns/1ps
`default_nettype none
module sfs_link_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe_n,
  input wire logic hold_n,
  input wire logic so_line
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ****************************************
  // device output side
  // ****************************************
  // margins cover the two-flop pin synchronisers
  chk_oe_deselect: assert property (cs_n [*8] |-> so_oe_n)
    else $error("data out driven while deselected");
  chk_oe_rises: assert property ($rose(cs_n) |-> ##[0:8] so_oe_n)
    else $error("data out kept after deselect");
  chk_oe_select: assert property ($fell(so_oe_n) |-> !cs_n && hold_n)
    else $error("data out driven outside a frame");
  chk_so_on_fall: assert property (!so_oe_n && $changed(so) |-> !sck)
    else $error("data out moved while clock high");
  chk_hold_release: assert property (
    (!hold_n && !sck && !cs_n) [*8] |-> so_oe_n && so_line)
    else $error("data out driven in hold");

  // ****************************************
  // host clock and data side
  // ****************************************
  // hold must freeze the divider, else bits are lost
  chk_hold_freeze: assert property (!hold_n [*3] |-> $stable(sck))
    else $error("serial clock moved in hold");
  chk_si_rise: assert property ($rose(sck) |-> $stable(si))
    else $error("data in moved at clock rise");
  chk_half_period: assert property (
    $changed(sck) |=> $stable(sck) [*7])
    else $error("serial clock half period too short");
endmodule
`default_nettype wire

// File: test/testbench.sv
// Purpose: host and device ends joined, driven over wishbone
// Assumes: HALF_DIV of 8, opcodes and map from the package
// Notes:   status is modelled here and compared bit for bit
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sfs_pkg::*;
  logic        clk_i       = 1'h0;
  logic        rst_i       = 1'h1;
  logic        busy_i      = 1'h0;
  logic        aai_mode_i  = 1'h0;
  logic        wel_clear_i = 1'h0;
  logic        cyc         = 1'h0;
  logic        stb         = 1'h0;
  logic        we          = 1'h0;
  logic [3:0]  adr         = 4'h0;
  logic [31:0] wdat        = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        cmd_valid;
  logic [7:0]  cmd_code;
  logic [7:0]  status;
  logic        held;
  logic        mode3       = 1'h0;
  logic        wp_hi       = 1'h1;
  logic [7:0]  exp_st      = 8'h0c;
  int          mismatches  = 0;
  int          comparisons = 0;
  int          cycles      = 0;
  int          pulses      = 0;

  // ****************************************
  // clock, ends and checker
  // ****************************************
  always #2.5 clk_i = ~clk_i;
  sfs_link_if link ();
  sfs_device sfs_device_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link),
    .busy_i(busy_i), .aai_mode_i(aai_mode_i), .wel_clear_i(wel_clear_i),
    .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code), .status_o(status),
    .held_o(held));
  sfs_host #(.HALF_DIV(8)) sfs_host_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .link(link));
  sfs_link_properties sfs_link_properties_inst (.clk_i(clk_i),
    .rst_i(rst_i), .sck(link.sck), .cs_n(link.cs_n), .si(link.si),
    .so(link.so), .so_oe_n(link.so_oe_n), .hold_n(link.hold_n),
    .so_line(link.so_line));

  // cycle ceiling, plus a count of opcode strobes
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cmd_valid === 1'h1) pulses <= pulses + 1;
    if (cycles == 60000) begin
      mismatches++;
      summarize();
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input string w, input logic [7:0] seen,
                       input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", w, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // request held until the edge that samples ack high; data taken there
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    cyc  <= 1'h1;
    stb  <= 1'h1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'h1);
    r = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clk_i);
  endtask
  task automatic ctrl(input logic s, input logic h);
    logic [31:0] r;
    wb(1'h1, REG_CTRL, {28'h0, mode3, wp_hi, h, s}, r);
  endtask
  task automatic poll();
    logic [31:0] r;
    do wb(1'h0, REG_STAT, 32'h0, r); while (r[STAT_XFER] === 1'h1);
  endtask
  task automatic xfer(input logic [7:0] b, output logic [7:0] got);
    logic [31:0] r;
    wb(1'h1, REG_DATA, {24'h0, b}, r);
    poll();
    wb(1'h0, REG_DATA, 32'h0, r);
    got = r[7:0];
  endtask
  task automatic frame(input logic [7:0] op, input logic [7:0] d,
                       input logic two, output logic [7:0] got);
    ctrl(1'h1, 1'h0);
    xfer(op, got);
    if (two) xfer(d, got);
    ctrl(1'h0, 1'h0);
  endtask
  task automatic chk_st(input string w);
    @(negedge clk_i);
    check(w, status, exp_st);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_read();
    logic [7:0] g;
    for (int m = 0; m < 2; m++) begin
      mode3 = m[0];
      ctrl(1'h0, 1'h0);
      frame(OP_STATUS_READ, 8'h00, 1'h1, g);
      check("link status", g, exp_st);
    end
  endtask
  task automatic t_wel();
    logic [7:0] g;
    frame(OP_WRITE_ENABLE, 8'h00, 1'h0, g);
    exp_st[ST_WEL] = 1'h1;
    chk_st("latch set");
    frame(OP_WRITE_DISABLE, 8'h00, 1'h0, g);
    exp_st[ST_WEL] = 1'h0;
    chk_st("latch cleared");
    frame(OP_WRITE_ENABLE, 8'h00, 1'h0, g);
    @(posedge clk_i);
    wel_clear_i <= 1'h1;
    @(posedge clk_i);
    wel_clear_i <= 1'h0;
    chk_st("latch event");
    frame(8'h9f, 8'h00, 1'h0, g);
    check("opcode", cmd_code, 8'h9f);
    check("strobes", 8'(pulses), 8'h01);
  endtask
  // hold lands before the first clock rise of the second byte
  task automatic t_hold();
    logic [31:0] r;
    logic [7:0]  g;
    ctrl(1'h1, 1'h0);
    xfer(OP_STATUS_READ, g);
    wb(1'h1, REG_DATA, 32'h0, r);
    ctrl(1'h1, 1'h1);
    repeat (12) @(negedge clk_i);
    check("held", 8'(held), 8'h01);
    check("line in hold", 8'(link.so_line), 8'h01);
    ctrl(1'h1, 1'h0);
    poll();
    wb(1'h0, REG_DATA, 32'h0, r);
    check("held byte", r[7:0], exp_st);
    ctrl(1'h1, 1'h1);
    ctrl(1'h0, 1'h1);
    repeat (12) @(negedge clk_i);
    check("held deselected", 8'(held), 8'h01);
    ctrl(1'h0, 1'h0);
    repeat (12) @(negedge clk_i);
    check("hold left", 8'(held), 8'h00);
    ctrl(1'h0, 1'h1);
    repeat (12) @(negedge clk_i);
    check("hold unselected", 8'(held), 8'h00);
    ctrl(1'h0, 1'h0);
    frame(OP_STATUS_READ, 8'h00, 1'h1, g);
    check("resumed", g, exp_st);
  endtask
  task automatic t_protect();
    logic [7:0] g;
    logic [7:0] dv [5] = '{8'h30, 8'h88, 8'h04, 8'h04, 8'h0c};
    logic [7:0] ev [5] = '{8'h00, 8'h88, 8'h88, 8'h04, 8'h0c};
    logic       wv [5] = '{1'h1, 1'h1, 1'h0, 1'h1, 1'h0};
    for (int i = 0; i < 5; i++) begin
      wp_hi = wv[i];
      frame(OP_STATUS_WRITE, dv[i], 1'h1, g);
      exp_st = ev[i];
      chk_st("status write");
    end
    wp_hi = 1'h1;
  endtask
  task automatic t_busy();
    logic [7:0] g;
    @(posedge clk_i);
    busy_i <= 1'h1;
    exp_st[ST_BUSY] = 1'h1;
    chk_st("busy flag");
    frame(OP_STATUS_READ, 8'h00, 1'h1, g);
    check("busy poll", g, exp_st);
    frame(OP_WRITE_ENABLE, 8'h00, 1'h0, g);
    chk_st("busy blocks latch");
    @(posedge clk_i);
    busy_i     <= 1'h0;
    aai_mode_i <= 1'h1;
    exp_st = 8'h4c;
    chk_st("program mode");
    @(posedge clk_i);
    aai_mode_i <= 1'h0;
    exp_st = 8'h0c;
  endtask
  // deselect after a few bits; the next opcode must start afresh
  task automatic t_abort();
    logic [31:0] r;
    logic [7:0]  g;
    ctrl(1'h1, 1'h0);
    wb(1'h1, REG_DATA, {24'h0, OP_WRITE_ENABLE}, r);
    repeat (40) @(posedge clk_i);
    ctrl(1'h0, 1'h0);
    poll();
    chk_st("aborted opcode");
    frame(OP_WRITE_ENABLE, 8'h00, 1'h0, g);
    exp_st[ST_WEL] = 1'h1;
    chk_st("fresh opcode");
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    repeat (3) @(posedge clk_i);
    chk_st("reset status");
    t_read();
    t_wel();
    mode3 = 1'h0;
    t_hold();
    t_protect();
    t_busy();
    t_abort();
    summarize();
  end
endmodule
`default_nettype wire
